// *** src/interrupt_standby_reset_ctrl.v ***
// Interrupt gating, standby clock control and reset merging for a small core.
// Functional notes
// - Seven interrupt and two test request flags.
// - Vector taken when source and master enabled.
// - Vector address from table entry, programmable except entries 2 and 8.
// - Nesting with priority select register.
// - Request flags readable by software.
// - Only enabled sources end standby.
// - External zero works in stop only with bypass bit.
// - Stop halts oscillator, CPU, timers, peripheral clock.
// - Halt gates only CPU clock.
// - Serial runs in stop on external clock.
// - Event counter runs in stop on pin.
// - External four works in both standbys.
// - Enabled request or pin reset leaves standby.
// - Reset from pin or watchdog.
// - Settling wait of 2^17 or 2^15 clocks.
// - Program counter loaded from bytes 0 and 1.
// - Bank enable flags from byte 0 bits 6, 7.
`timescale 1ns/10ps
`default_nettype none
`include "irq_standby_regs.vh"
module interrupt_standby_reset_ctrl #(
  parameter NSRC = 9,
  parameter LONG_WAIT = 1 << `WAIT_LONG_LOG2,
  parameter SHORT_WAIT = 1 << `WAIT_SHORT_LOG2
) (
  // Clock and reset.
  input wire sys_clk,
  input wire nrst,
  // Mask option and external pins.
  input wire long_wait_opt,
  input wire ext_irq_zero,
  input wire ext_irq_four,
  input wire watchdog_reset_req,
  // Peripheral request pulses, one per source; serial external clock tick and event counter pin.
  input wire [NSRC-1:0] periph_req,
  input wire sio_ext_clk_tick,
  input wire event_count_input,
  // Program memory bytes 0000 and 0001.
  input wire [7:0] boot_byte0,
  input wire [7:0] boot_byte1,
  // Core handshake.
  input wire vector_ack,
  input wire service_done,
  input wire stop_instr,
  input wire halt_instr,
  // Register port.
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Outputs to core and clock tree.
  output reg vector_req,
  output reg [7:0] vector_addr,
  output reg [3:0] vector_src,
  output reg cpu_clk_en,
  output reg osc_en,
  output reg periph_clk_en,
  output reg sio_run,
  output reg tmr_run,
  output reg int_rst_n,
  output reg [12:0] pc_reset_value,
  output reg regbank_enable_flag,
  output reg membank_enable_flag,
  output reg irq_out
);
  localparam ST_RUN = 3'b001;
  localparam ST_HALT = 3'b010;
  localparam ST_STOP = 3'b100;

  reg [1:0] rst_sync_q;
  wire rst_n = rst_sync_q[1];
  reg [1:0] z_sync_q;
  reg [1:0] f_sync_q;
  reg [1:0] wd_sync_q;
  reg [1:0] ev_sync_q;
  reg z_prev_q;
  reg f_prev_q;
  reg ev_prev_q;
  reg [NSRC-1:0] req_q;
  reg [NSRC-1:0] req_d;
  reg [NSRC-1:0] src_en_q;
  reg global_irq_enable_q;
  reg sio_ext_q;
  reg tmr_ext_q;
  reg [3:0] irq_priority_select_q;
  reg [3:0] ext_irq0_edge_mode_q;
  reg [7:0] vec_q [0:NSRC-1];
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg in_service_q;
  reg in_hi_q;
  reg [17:0] wait_q;
  reg waiting_q;
  reg [15:0] tick_q;
  reg [2:0] evt_q;
  reg [2:0] evt_en_q;
  reg [3:0] sel;
  reg sel_valid;
  integer i;
  integer j;
  integer k;

  wire ext_irq0_filter_bypass = ext_irq0_edge_mode_q[`EDGE_BYPASS_BIT];
  wire z_rise = z_sync_q[1] & ~z_prev_q;
  wire f_rise = f_sync_q[1] & ~f_prev_q;
  wire ev_rise = ev_sync_q[1] & ~ev_prev_q;
  wire osc_running = state_q != ST_STOP;
  wire wr_clr = reg_wr && reg_addr == `ADDR_REQ_CLR;
  wire [NSRC-1:0] wake_vec = req_q & src_en_q;
  wire ext_rst = ~rst_n;
  wire any_rst = ext_rst | wd_sync_q[1];

  // Synchronise reset release and the zero, four, watchdog and event pins.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      z_sync_q <= 2'b00;
      f_sync_q <= 2'b00;
      wd_sync_q <= 2'b00;
      ev_sync_q <= 2'b00;
      z_prev_q <= 1'b0;
      f_prev_q <= 1'b0;
      ev_prev_q <= 1'b0;
    end else begin
      z_sync_q <= {z_sync_q[0], ext_irq_zero};
      f_sync_q <= {f_sync_q[0], ext_irq_four};
      wd_sync_q <= {wd_sync_q[0], watchdog_reset_req};
      ev_sync_q <= {ev_sync_q[0], event_count_input};
      z_prev_q <= z_sync_q[1];
      f_prev_q <= f_sync_q[1];
      ev_prev_q <= ev_sync_q[1];
    end
  end

  // Request flag set and clear; a set wins over a clear.
  always @* begin
    req_d = req_q;
    if (wr_clr) begin
      req_d = req_q & ~{reg_wdata[0], reg_wdata};
    end
    if (vector_ack && sel_valid) begin
      req_d[sel] = 1'b0;
    end
    for (i = 0; i < NSRC; i = i + 1) begin
      if (periph_req[i] && osc_running) begin
        req_d[i] = 1'b1;
      end
    end
    if (z_rise && (ext_irq0_filter_bypass || osc_running)) begin
      req_d[`IRQ_ZERO_IDX] = 1'b1;
    end
    if (f_rise) begin
      req_d[`IRQ_FOUR_IDX] = 1'b1;
    end
    if (tick_q == 16'h0000 && osc_running) begin
      req_d[`IRQ_TIMER_IDX] = 1'b1;
    end
  end

  always @* begin
    sel = 4'h0;
    sel_valid = 1'b0;
    for (j = NSRC - 1; j >= 0; j = j - 1) begin
      if (wake_vec[j] && global_irq_enable_q &&
          (!in_service_q ||
           (!in_hi_q && j == irq_priority_select_q))) begin
        sel = j[3:0];
        sel_valid = 1'b1;
      end
    end
    if (wake_vec[irq_priority_select_q] && global_irq_enable_q &&
        !in_hi_q && irq_priority_select_q < NSRC) begin
      sel = irq_priority_select_q;
      sel_valid = 1'b1;
    end
  end

  // Standby state machine.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (stop_instr) begin
          state_d = ST_STOP;
        end else if (halt_instr) begin
          state_d = ST_HALT;
        end
      end
      ST_HALT: begin
        if (|wake_vec) begin
          state_d = ST_RUN;
        end
      end
      ST_STOP: begin
        if (|wake_vec) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= `SRC_EN_RST;
      src_en_q <= `SRC_EN_RST;
      global_irq_enable_q <= 1'b0;
      sio_ext_q <= 1'b0;
      tmr_ext_q <= 1'b0;
      irq_priority_select_q <= `PRIO_RST;
      ext_irq0_edge_mode_q <= 4'h0;
      state_q <= ST_RUN;
      in_service_q <= 1'b0;
      in_hi_q <= 1'b0;
      tick_q <= `TICK_RST;
      evt_q <= 3'b000;
      evt_en_q <= 3'b000;
      reg_rdata <= 8'h00;
      vector_req <= 1'b0;
      vector_addr <= 8'h00;
      vector_src <= 4'h0;
      irq_out <= 1'b0;
      for (k = 0; k < NSRC; k = k + 1) begin
        vec_q[k] <= 8'h00;
      end
    end else begin
      req_q <= req_d;
      state_q <= state_d;
      if (osc_running) begin
        tick_q <= tick_q - 16'h0001;
      end
      // programmable vector
      // The request drops with the acknowledge so it is never seen twice.
      vector_req <= sel_valid && state_q == ST_RUN && !vector_ack;
      vector_addr <= vec_q[sel];
      vector_src <= sel;
      if (vector_ack && sel_valid) begin
        in_hi_q <= in_service_q;
        in_service_q <= 1'b1;
      end else if (service_done) begin
        if (in_hi_q) begin
          in_hi_q <= 1'b0;
        end else begin
          in_service_q <= 1'b0;
        end
      end
      if (reg_wr) begin
        case (reg_addr)
          `ADDR_SRC_EN: src_en_q <= {reg_wdata[0], reg_wdata};
          `ADDR_CTRL: begin
            global_irq_enable_q <= reg_wdata[`CTRL_GIE_BIT];
            sio_ext_q <= reg_wdata[`CTRL_SIO_EXT_BIT];
            tmr_ext_q <= reg_wdata[`CTRL_TMR_EXT_BIT];
          end
          `ADDR_PRIO: irq_priority_select_q <= reg_wdata[3:0];
          `ADDR_EDGE_MODE: ext_irq0_edge_mode_q <= reg_wdata[3:0];
          `ADDR_EVT_EN: evt_en_q <= reg_wdata[2:0];
          default: begin
            if (reg_addr >= `ADDR_VEC_BASE &&
                reg_addr - `ADDR_VEC_BASE < NSRC) begin
              vec_q[reg_addr - `ADDR_VEC_BASE] <= reg_wdata;
            end
          end
        endcase
      end
      // Events: standby entry, standby exit, watchdog reset.
      evt_q <= (evt_q & ~((reg_wr && reg_addr == `ADDR_EVT_CLR) ?
        reg_wdata[2:0] : 3'b000)) |
        {wd_sync_q[1], state_q != ST_RUN && state_d == ST_RUN,
         state_q == ST_RUN && state_d != ST_RUN};
      irq_out <= |(evt_q & evt_en_q);
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `ADDR_REQ_FLAGS: reg_rdata <= req_q[7:0];
          `ADDR_REQ_CLR: reg_rdata <= {7'h00, req_q[8]};
          `ADDR_SRC_EN: reg_rdata <= src_en_q[7:0];
          `ADDR_CTRL: reg_rdata <= {3'b000, state_q[1], state_q[2],
            tmr_ext_q, sio_ext_q, global_irq_enable_q};
          `ADDR_PRIO: reg_rdata <= {4'h0, irq_priority_select_q};
          `ADDR_STATUS: reg_rdata <= {5'h00, evt_q};
          `ADDR_EVT_STAT: reg_rdata <= {5'h00, evt_q};
          `ADDR_EVT_EN: reg_rdata <= {5'h00, evt_en_q};
          `ADDR_EDGE_MODE: reg_rdata <= {4'h0, ext_irq0_edge_mode_q};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_en <= 1'b0;
      osc_en <= 1'b1;
      periph_clk_en <= 1'b0;
      sio_run <= 1'b0;
      tmr_run <= 1'b0;
    end else begin
      cpu_clk_en <= state_d == ST_RUN && int_rst_n;
      osc_en <= state_d != ST_STOP;
      periph_clk_en <= state_d != ST_STOP;
      sio_run <= state_d != ST_STOP || (sio_ext_q && sio_ext_clk_tick);
      tmr_run <= state_d != ST_STOP || (tmr_ext_q && ev_rise);
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      int_rst_n <= 1'b0;
      waiting_q <= 1'b1;
      wait_q <= 18'h0_0000;
      pc_reset_value <= 13'h0000;
      regbank_enable_flag <= 1'b0;
      membank_enable_flag <= 1'b0;
    end else if (any_rst) begin
      int_rst_n <= 1'b0;
      waiting_q <= 1'b1;
      wait_q <= 18'h0_0000;
    end else if (waiting_q) begin
      wait_q <= wait_q + 18'h0_0001;
      if (wait_q == (long_wait_opt ? LONG_WAIT - 1 : SHORT_WAIT - 1)) begin
        waiting_q <= 1'b0;
        int_rst_n <= 1'b1;
        pc_reset_value <= {boot_byte0[4:0], boot_byte1};
        regbank_enable_flag <= boot_byte0[`BOOT_RBE_BIT];
        membank_enable_flag <= boot_byte0[`BOOT_MBE_BIT];
      end
    end
  end
endmodule // interrupt_standby_reset_ctrl
`default_nettype wire

// *** src/irq_standby_regs.vh ***
// Offsets, field positions, reset values and timing counts of the controller.
`ifndef IRQ_STANDBY_REGS_VH
`define IRQ_STANDBY_REGS_VH
`define ADDR_REQ_FLAGS 4'h0
`define ADDR_SRC_EN 4'h1
`define ADDR_CTRL 4'h2
`define ADDR_PRIO 4'h3
`define ADDR_REQ_CLR 4'h4
`define ADDR_VEC_BASE 4'h8
`define ADDR_STATUS 4'h5
`define ADDR_EVT_STAT 4'h6
`define ADDR_EVT_EN 4'h7
`define ADDR_EVT_CLR 4'h9
`define ADDR_EDGE_MODE 4'hA
`define ADDR_BOOT 4'hB
`define CTRL_GIE_BIT 0
`define CTRL_SIO_EXT_BIT 1
`define CTRL_TMR_EXT_BIT 2
`define CTRL_STOP_BIT 3
`define CTRL_HALT_BIT 4
`define EDGE_BYPASS_BIT 2
`define BOOT_RBE_BIT 6
`define BOOT_MBE_BIT 7
`define IRQ_ZERO_IDX 0
`define IRQ_FOUR_IDX 1
`define IRQ_TIMER_IDX 2
`define SRC_EN_RST 9'h000
`define PRIO_RST 4'h0
`define WAIT_LONG_LOG2 17
`define WAIT_SHORT_LOG2 15
`define TICK_RST 16'h0400
`endif

// *** verif/irq_standby_properties.sv ***
// Concurrent checks on the ports of the interrupt and standby controller.
`timescale 1ns/10ps
`default_nettype none
module irq_standby_properties #(
  parameter LONG_WAIT = 64,
  parameter SHORT_WAIT = 16
) (
  // Clock and reset.
  input wire sys_clk,
  input wire nrst,
  // Causes.
  input wire long_wait_opt,
  input wire watchdog_reset_req,
  input wire stop_instr,
  input wire halt_instr,
  input wire vector_ack,
  input wire reg_rd,
  input wire [7:0] boot_byte0,
  input wire [7:0] boot_byte1,
  // Outputs under check.
  input wire [7:0] reg_rdata,
  input wire vector_req,
  input wire [7:0] vector_addr,
  input wire cpu_clk_en,
  input wire osc_en,
  input wire periph_clk_en,
  input wire int_rst_n,
  input wire [12:0] pc_reset_value,
  input wire regbank_enable_flag,
  input wire membank_enable_flag
);
  logic [31:0] low_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Counts the cycles of the current internal reset phase.
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      low_q <= 32'h0000_0000;
    end else if (!int_rst_n) begin
      low_q <= low_q + 32'h0000_0001;
    end else begin
      low_q <= 32'h0000_0000;
    end
  end
  a_wait_min: assert property (
    $rose(int_rst_n) |-> low_q + 2 >= (long_wait_opt ? LONG_WAIT : SHORT_WAIT))
    else $error("settling wait too short");
  a_wdog_reset: assert property (
    $rose(watchdog_reset_req) |-> ##[1:5] !int_rst_n)
    else $error("watchdog request gave no internal reset");
  a_boot_load: assert property (
    int_rst_n |-> pc_reset_value == {boot_byte0[4:0], boot_byte1}
      && regbank_enable_flag == boot_byte0[6]
      && membank_enable_flag == boot_byte0[7])
    else $error("boot values not loaded");
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  a_cpu_needs_osc: assert property (
    !osc_en |-> !cpu_clk_en && !periph_clk_en)
    else $error("clocks run with oscillator stopped");
  a_stop_entry: assert property (
    $rose(stop_instr) && cpu_clk_en |-> ##[1:4] !osc_en)
    else $error("stop did not halt oscillator");
  a_halt_entry: assert property (
    $rose(halt_instr) && cpu_clk_en |->
      ##[1:4] (!cpu_clk_en && osc_en && periph_clk_en))
    else $error("halt gated more than the cpu clock");
  a_vec_hold: assert property (
    vector_req && !vector_ack |=> vector_req && $stable(vector_addr))
    else $error("vector request dropped before ack");
endmodule // irq_standby_properties
bind interrupt_standby_reset_ctrl irq_standby_properties #(
  .LONG_WAIT(LONG_WAIT),
  .SHORT_WAIT(SHORT_WAIT)
) irq_standby_properties_inst (.*);
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the interrupt, standby and reset controller.
`timescale 1ns/10ps
`default_nettype none
`include "irq_standby_regs.vh"
module tb_top;
  localparam int LW = 64;
  localparam int SW = 16;
  logic sys_clk, nrst, long_wait_opt, ext_irq_zero, ext_irq_four;
  logic watchdog_reset_req, sio_ext_clk_tick, event_count_input;
  logic vector_ack, service_done, stop_instr, halt_instr, reg_wr, reg_rd;
  logic [8:0] periph_req;
  logic [7:0] boot_byte0, boot_byte1, reg_wdata;
  logic [3:0] reg_addr;
  wire [7:0] reg_rdata, vector_addr;
  wire [3:0] vector_src;
  wire [12:0] pc_reset_value;
  wire vector_req, cpu_clk_en, osc_en, periph_clk_en, sio_run, tmr_run;
  wire int_rst_n, regbank_enable_flag, membank_enable_flag, irq_out;
  int mismatches, total_checks, n;
  interrupt_standby_reset_ctrl #(.LONG_WAIT(LW), .SHORT_WAIT(SW))
    interrupt_standby_reset_ctrl_inst (.*);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return cpu_clk_en;
      1: return vector_req;
      2: return irq_out;
      3: return osc_en;
      default: return int_rst_n;
    endcase
  endfunction
  task automatic wait_sig(input int s, input logic v);
    n = 0;
    while (pick(s) !== v && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(pick(s), v);
    if (pick(s) !== v) final_report();
  endtask
  task automatic wait_boot(input int w);
    wait_sig(4, 1'b0);
    n = 0;
    while (int_rst_n !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(n >= w && n <= w + 12, 1);
    if (int_rst_n !== 1'b1) final_report();
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    {mismatches, total_checks} = 0;
    {nrst, ext_irq_zero, ext_irq_four, watchdog_reset_req} = 4'h0;
    {sio_ext_clk_tick, event_count_input, vector_ack, service_done} = 4'h0;
    {stop_instr, halt_instr, reg_wr, reg_rd, periph_req} = 13'h0000;
    {reg_addr, reg_wdata} = 12'h000;
    long_wait_opt = 1'b1;
    boot_byte0 = 8'h93;
    boot_byte1 = 8'h5C;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    wait_boot(LW - 4);
    chk(pc_reset_value, 13'h135C);
    chk({membank_enable_flag, regbank_enable_flag}, 2'b10);
    rd(`ADDR_SRC_EN, 8'h00);
    rd(`ADDR_PRIO, 8'h00);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    wr(`ADDR_VEC_BASE, 8'h5A);
    wr(`ADDR_SRC_EN, 8'h01);
    @(posedge sys_clk) periph_req <= 9'h001;
    @(posedge sys_clk) periph_req <= 9'h000;
    rd(`ADDR_REQ_FLAGS, 8'h01);
    chk(vector_req, 1'b0);
    wr(`ADDR_CTRL, 8'h01);
    wait_sig(1, 1'b1);
    chk(vector_addr, 8'h5A);
    chk(vector_src, 4'h0);
    @(posedge sys_clk) vector_ack <= 1'b1;
    @(posedge sys_clk) vector_ack <= 1'b0;
    wr(`ADDR_REQ_CLR, 8'hFF);
    rd(`ADDR_REQ_FLAGS, 8'h00);
    @(posedge sys_clk) service_done <= 1'b1;
    @(posedge sys_clk) service_done <= 1'b0;
    wr(`ADDR_CTRL, 8'h00);
    @(posedge sys_clk) halt_instr <= 1'b1;
    @(posedge sys_clk) halt_instr <= 1'b0;
    wait_sig(0, 1'b0);
    chk({osc_en, periph_clk_en, irq_out}, 3'b110);
    rd(`ADDR_EVT_STAT, 8'h01);
    wr(`ADDR_EVT_EN, 8'h01);
    wait_sig(2, 1'b1);
    @(posedge sys_clk) periph_req <= 9'h002;
    @(posedge sys_clk) periph_req <= 9'h000;
    repeat (8) @(posedge sys_clk);
    chk(cpu_clk_en, 1'b0);
    @(posedge sys_clk) periph_req <= 9'h001;
    @(posedge sys_clk) periph_req <= 9'h000;
    wait_sig(0, 1'b1);
    wr(`ADDR_EVT_CLR, 8'h07);
    wait_sig(2, 1'b0);
    wr(`ADDR_REQ_CLR, 8'hFF);
    wr(`ADDR_SRC_EN, 8'h03);
    @(posedge sys_clk) stop_instr <= 1'b1;
    @(posedge sys_clk) stop_instr <= 1'b0;
    wait_sig(3, 1'b0);
    chk(periph_clk_en, 1'b0);
    @(posedge sys_clk) ext_irq_zero <= 1'b1;
    sio_ext_clk_tick <= 1'b1;
    event_count_input <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(sio_run, 1'b0);
    chk(tmr_run, 1'b0);
    repeat (7) @(posedge sys_clk);
    chk(osc_en, 1'b0);
    @(posedge sys_clk) ext_irq_four <= 1'b1;
    wait_sig(0, 1'b1);
    @(posedge sys_clk);
    {ext_irq_zero, ext_irq_four, event_count_input} <= 3'b000;
    wr(`ADDR_REQ_CLR, 8'hFF);
    wr(`ADDR_EDGE_MODE, 8'h04);
    wr(`ADDR_CTRL, 8'h06);
    @(posedge sys_clk) stop_instr <= 1'b1;
    @(posedge sys_clk) stop_instr <= 1'b0;
    wait_sig(3, 1'b0);
    chk(sio_run, 1'b1);
    @(posedge sys_clk) event_count_input <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(tmr_run, 1'b1);
    @(posedge sys_clk) ext_irq_zero <= 1'b1;
    wait_sig(0, 1'b1);
    repeat (`TICK_RST) @(posedge sys_clk);
    rd(`ADDR_REQ_FLAGS, 8'h05);
    @(posedge sys_clk) watchdog_reset_req <= 1'b1;
    long_wait_opt <= 1'b0;
    repeat (2) @(posedge sys_clk);
    watchdog_reset_req <= 1'b0;
    wait_boot(SW - 4);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
